// *** hw/shid_defines.vh ***
`ifndef SHID_DEFINES_VH
`define SHID_DEFINES_VH

`define SHID_MAG_W 16
`define SHID_RATIO_MIN 7'h05
`define SHID_RATIO_MAX 7'h32
`define SHID_RATIO_RST 7'h0f
`define SHID_BASE_MIN 7'h14
`define SHID_BASE_MAX 7'h64
`define SHID_BASE_RST 7'h1e
`define SHID_PCT_SCALE 7'h64
`define SHID_NOMINAL_RST 16'h0400

`define SHID_ADDR_W 4
`define SHID_REG_CTRL 4'h0
`define SHID_REG_RATIO 4'h1
`define SHID_REG_BASE 4'h2
`define SHID_REG_NOMINAL 4'h3
`define SHID_REG_FLAGS 4'h4
`define SHID_REG_IRQ_STAT 4'h5
`define SHID_REG_IRQ_CLR 4'h6
`define SHID_REG_IRQ_EN 4'h7
`define SHID_REG_EVENT 4'h8

`define SHID_CTRL_ENABLE 0
`define SHID_IRQ_RISE 0
`define SHID_IRQ_FALL 1
`define SHID_IRQ_LOST 2

`endif

// *** hw/shid_phase.v ***
`timescale 1ns/1ps
`include "shid_defines.vh"

module shid_phase #(
  parameter MAG_W = `SHID_MAG_W
) (
  input wire [MAG_W-1:0] fund_mag,
  input wire [MAG_W-1:0] harm2_mag,
  input wire [6:0] ratio_pct,
  input wire [6:0] base_pct,
  input wire [MAG_W-1:0] nominal_mag,
  output wire detect
);
  wire [MAG_W+6:0] harm_scaled;
  wire [MAG_W+6:0] fund_scaled;
  wire [MAG_W+6:0] fund_x100;
  wire [MAG_W+6:0] base_level;
  wire ratio_hit;
  wire level_ok;

  // ratio test without a divider
  assign harm_scaled = harm2_mag * `SHID_PCT_SCALE; // [RL11]
  assign fund_scaled = fund_mag * ratio_pct; // [RL11]
  assign ratio_hit = harm_scaled > fund_scaled; // [RL2]
  // minimum level scaled by nominal current
  assign fund_x100 = fund_mag * `SHID_PCT_SCALE; // [RL4]
  assign base_level = nominal_mag * base_pct; // [RL4]
  assign level_ok = fund_x100 > base_level; // [RL3]
  assign detect = ratio_hit & level_ok; // [RL9]
endmodule

// *** hw/shid_detector.v ***
// What this block does
// RL1: the detector works only while enabled (off after reset) and the block input forces all flags low.
// RL2: the ratio threshold is 5 to 50 percent in steps of 1, default 15, applied to second harmonic over fundamental.
// RL3: the minimum fundamental level is 20 to 100 percent, default 30, and no inrush is declared at or below it.
// RL4: the minimum level is a percentage of the nominal current value.
// RL5: upstream logic supplies fundamental and second harmonic magnitudes for all three phases.
// RL6: each phase has its own flag driven only from its own evaluation.
// RL7: the general flag is high when any phase flag is high and low when none is.
// RL8: every change of the general flag produces an on or off event for the event list and supervisory system.
// RL9: a phase flag is set when its ratio is above threshold and its fundamental passes the level test.
// RL10: the three phase evaluations are independent of each other.
// RL11: the ratio test uses cross multiplication, evaluated on each update strobe with registered outputs.
`timescale 1ns/1ps
`include "shid_defines.vh"

module shid_detector #(
  parameter MAG_W = `SHID_MAG_W
) (
  input wire core_clk,
  input wire reset,
  input wire [MAG_W-1:0] fund_l1,
  input wire [MAG_W-1:0] fund_l2,
  input wire [MAG_W-1:0] fund_l3,
  input wire [MAG_W-1:0] harm2_l1,
  input wire [MAG_W-1:0] harm2_l2,
  input wire [MAG_W-1:0] harm2_l3,
  input wire fourier_update,
  input wire inrush_block_in,
  input wire [`SHID_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg inrush_phase1_out,
  output reg inrush_phase2_out,
  output reg inrush_phase3_out,
  output reg inrush_any_phase_out,
  output reg inrush_event_valid,
  output reg inrush_event_on,
  output reg irq
);
  reg enable_r;
  reg [6:0] ratio_r;
  reg [6:0] base_r;
  reg [MAG_W-1:0] nominal_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;
  reg event_pend_r;
  reg event_val_r;
  wire [3*MAG_W-1:0] fund_bus;
  wire [3*MAG_W-1:0] harm_bus;
  wire [2:0] detect;
  wire [2:0] phase_nxt;
  wire any_nxt;
  wire any_change;
  wire active;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  wire [2:0] irq_stat_nxt;
  wire [6:0] wr_pct;
  wire wr_big;
  reg [31:0] rdata_nxt;

  assign fund_bus = {fund_l3, fund_l2, fund_l1}; // [RL5]
  assign harm_bus = {harm2_l3, harm2_l2, harm2_l1}; // [RL5]

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ph
      // one evaluator per phase, no shared state
      shid_phase #(.MAG_W(MAG_W)) u_phase ( // [RL10]
        .fund_mag(fund_bus[g*MAG_W +: MAG_W]),
        .harm2_mag(harm_bus[g*MAG_W +: MAG_W]),
        .ratio_pct(ratio_r),
        .base_pct(base_r),
        .nominal_mag(nominal_r),
        .detect(detect[g])
      );
    end
  endgenerate

  assign active = enable_r & ~inrush_block_in; // [RL1]
  assign phase_nxt = active ? detect : 3'b000; // [RL1] [RL6]
  assign any_nxt = |phase_nxt; // [RL7]
  assign any_change = fourier_update & (any_nxt != inrush_any_phase_out); // [RL8]
  assign wr_pct = reg_wdata[6:0];
  // high bits set means the value is above any legal setting
  assign wr_big = |reg_wdata[31:7];

  // flag outputs updated once per fourier strobe; block acts at once
  always @(posedge core_clk) begin
    if (reset) begin
      inrush_phase1_out <= 1'b0;
      inrush_phase2_out <= 1'b0;
      inrush_phase3_out <= 1'b0;
      inrush_any_phase_out <= 1'b0;
    end else if (fourier_update) begin
      inrush_phase1_out <= phase_nxt[0]; // [RL11] [RL6]
      inrush_phase2_out <= phase_nxt[1]; // [RL11] [RL6]
      inrush_phase3_out <= phase_nxt[2]; // [RL11] [RL6]
      inrush_any_phase_out <= any_nxt; // [RL7]
    end else if (~active) begin
      inrush_phase1_out <= 1'b0; // [RL1]
      inrush_phase2_out <= 1'b0; // [RL1]
      inrush_phase3_out <= 1'b0; // [RL1]
      inrush_any_phase_out <= 1'b0; // [RL1]
    end
  end

  // forced clear outside a strobe also changes the general flag
  wire force_drop;
  assign force_drop = ~fourier_update & ~active & inrush_any_phase_out;

  // event record: pulse with value, plus holding register for software
  always @(posedge core_clk) begin
    if (reset) begin
      inrush_event_valid <= 1'b0;
      inrush_event_on <= 1'b0;
      event_pend_r <= 1'b0;
      event_val_r <= 1'b0;
    end else begin
      inrush_event_valid <= any_change | force_drop; // [RL8]
      if (any_change | force_drop) begin
        inrush_event_on <= any_change & any_nxt; // [RL8]
        event_val_r <= any_change & any_nxt; // [RL8]
        event_pend_r <= 1'b1;
      end else if (reg_rd && reg_addr == `SHID_REG_EVENT) begin
        event_pend_r <= 1'b0;
      end
    end
  end

  // interrupt status: rise, fall, event overwritten before read
  assign irq_set[`SHID_IRQ_RISE] = any_change & any_nxt;
  assign irq_set[`SHID_IRQ_FALL] = (any_change & ~any_nxt) | force_drop;
  assign irq_set[`SHID_IRQ_LOST] = (any_change | force_drop) & event_pend_r;
  assign irq_clr = (reg_wr && reg_addr == `SHID_REG_IRQ_CLR) ? reg_wdata[2:0] : 3'b000;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  always @(posedge core_clk) begin
    if (reset) begin
      irq_stat_r <= 3'b000;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // settings; ratio and base clamped to their legal ranges
  always @(posedge core_clk) begin
    if (reset) begin
      enable_r <= 1'b0; // [RL1]
      ratio_r <= `SHID_RATIO_RST; // [RL2]
      base_r <= `SHID_BASE_RST; // [RL3]
      nominal_r <= `SHID_NOMINAL_RST; // [RL4]
      irq_en_r <= 3'b000;
    end else if (reg_wr) begin
      case (reg_addr)
        `SHID_REG_CTRL: enable_r <= reg_wdata[`SHID_CTRL_ENABLE];
        `SHID_REG_RATIO: begin
          if (wr_big) ratio_r <= `SHID_RATIO_MAX; // [RL2]
          else if (wr_pct < `SHID_RATIO_MIN) ratio_r <= `SHID_RATIO_MIN; // [RL2]
          else if (wr_pct > `SHID_RATIO_MAX) ratio_r <= `SHID_RATIO_MAX; // [RL2]
          else ratio_r <= wr_pct;
        end
        `SHID_REG_BASE: begin
          if (wr_big) base_r <= `SHID_BASE_MAX; // [RL3]
          else if (wr_pct < `SHID_BASE_MIN) base_r <= `SHID_BASE_MIN; // [RL3]
          else if (wr_pct > `SHID_BASE_MAX) base_r <= `SHID_BASE_MAX; // [RL3]
          else base_r <= wr_pct;
        end
        `SHID_REG_NOMINAL: nominal_r <= reg_wdata[MAG_W-1:0];
        `SHID_REG_IRQ_EN: irq_en_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      `SHID_REG_CTRL: rdata_nxt[0] = enable_r;
      `SHID_REG_RATIO: rdata_nxt[6:0] = ratio_r;
      `SHID_REG_BASE: rdata_nxt[6:0] = base_r;
      `SHID_REG_NOMINAL: rdata_nxt[MAG_W-1:0] = nominal_r;
      `SHID_REG_FLAGS: rdata_nxt[3:0] = {inrush_any_phase_out, inrush_phase3_out,
                                          inrush_phase2_out, inrush_phase1_out};
      `SHID_REG_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
      `SHID_REG_IRQ_EN: rdata_nxt[2:0] = irq_en_r;
      `SHID_REG_EVENT: rdata_nxt[1:0] = {event_pend_r, event_val_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// *** test/shid_checker.sv ***
`timescale 1ns/1ps
module shid_checker (
  input logic core_clk,
  input logic reset,
  input logic fourier_update,
  input logic inrush_block_in,
  input logic inrush_phase1_out,
  input logic inrush_phase2_out,
  input logic inrush_phase3_out,
  input logic inrush_any_phase_out,
  input logic inrush_event_valid,
  input logic inrush_event_on
);
  wire [2:0] ph = {inrush_phase3_out, inrush_phase2_out, inrush_phase1_out};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence s_rise;
    fourier_update ##1 $rose(inrush_any_phase_out);
  endsequence
  AST_BLOCK: assert property (inrush_block_in |=> ph == 3'h0)
    else $error("flag high under block");
  AST_ANY: assert property (inrush_any_phase_out == |ph)
    else $error("general flag wrong");
  AST_EV_SET: assert property ($changed(inrush_any_phase_out) |-> inrush_event_valid)
    else $error("event missing");
  AST_EV_ONLY: assert property (inrush_event_valid |-> $changed(inrush_any_phase_out))
    else $error("spurious event");
  AST_EV_VAL: assert property (inrush_event_valid |-> inrush_event_on == inrush_any_phase_out)
    else $error("event value wrong");
  AST_EV_HOLD: assert property (!inrush_event_valid |-> $stable(inrush_event_on))
    else $error("event value moved");
  AST_STROBE: assert property ((ph & ~$past(ph)) != 3'h0 |-> $past(fourier_update))
    else $error("flag rose without strobe");
  AST_RISE: assert property (s_rise |-> inrush_event_valid && inrush_event_on)
    else $error("on event missing");
endmodule
bind shid_detector shid_checker chk_i (.core_clk(core_clk), .reset(reset),
  .fourier_update(fourier_update), .inrush_block_in(inrush_block_in),
  .inrush_phase1_out(inrush_phase1_out), .inrush_phase2_out(inrush_phase2_out),
  .inrush_phase3_out(inrush_phase3_out), .inrush_any_phase_out(inrush_any_phase_out),
  .inrush_event_valid(inrush_event_valid), .inrush_event_on(inrush_event_on));

// *** test/shid_source.sv ***
`timescale 1ns/1ps
module shid_source (
  input logic core_clk,
  output logic [15:0] fund_l1,
  output logic [15:0] fund_l2,
  output logic [15:0] fund_l3,
  output logic [15:0] harm2_l1,
  output logic [15:0] harm2_l2,
  output logic [15:0] harm2_l3,
  output logic fourier_update
);
  initial {fund_l1, fund_l2, fund_l3, harm2_l1, harm2_l2, harm2_l3, fourier_update} = '0;
  task send(input logic [15:0] a, b, c, x, y, z);
    @(posedge core_clk);
    fourier_update <= 1'b1;
    {fund_l1, fund_l2, fund_l3, harm2_l1, harm2_l2, harm2_l3} <= {a, b, c, x, y, z};
    @(posedge core_clk);
    fourier_update <= 1'b0;
    {fund_l1, fund_l2, fund_l3, harm2_l1, harm2_l2, harm2_l3} <= ~{a, b, c, x, y, z};
  endtask
endmodule

// *** test/test_second_harmonic_inrush_detector.sv ***
`timescale 1ns/1ps
module test_second_harmonic_inrush_detector;
  logic core_clk = 0, reset = 1, blk = 0, wr = 0, rd = 0, act = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, ratio = 15, base = 30, nom = 32'h0000_0400;
  wire [31:0] rdat;
  wire [15:0] f1, f2, f3, h1, h2, h3;
  wire upd, p1, p2, p3, any, ev, evon, irq;
  logic [2:0] e;
  int fails = 0, check_count = 0;
  always #2.5 core_clk = ~core_clk;
  shid_source src (.core_clk(core_clk), .fund_l1(f1), .fund_l2(f2), .fund_l3(f3), .harm2_l1(h1),
    .harm2_l2(h2), .harm2_l3(h3), .fourier_update(upd));
  shid_detector uut (.core_clk(core_clk), .reset(reset), .fund_l1(f1), .fund_l2(f2), .fund_l3(f3),
    .harm2_l1(h1), .harm2_l2(h2), .harm2_l3(h3), .fourier_update(upd), .inrush_block_in(blk),
    .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .inrush_phase1_out(p1),
    .inrush_phase2_out(p2), .inrush_phase3_out(p3), .inrush_any_phase_out(any),
    .inrush_event_valid(ev), .inrush_event_on(evon), .irq(irq));
  task chk(input string n, input logic [31:0] x, g);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    @(posedge core_clk);
    {wr, rd} <= 2'b00;
    #1 if (!w) chk("rdata", d, rdat);
  endtask
  function logic det(input logic [31:0] f, h);
    return 100 * h > ratio * f && 100 * f > base * nom;
  endfunction
  task shot(input logic [31:0] a, b, c, x, y, z);
    src.send(a[15:0], b[15:0], c[15:0], x[15:0], y[15:0], z[15:0]);
    #1 e = act ? {det(c, z), det(b, y), det(a, x)} : 3'h0;
    chk("flags", {|e, e}, {any, p3, p2, p1});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(63863));
    repeat (5) @(posedge core_clk);
    reset <= 0;
    bus(0, 4'h0, 0);
    bus(0, 4'h1, 15);
    bus(0, 4'h2, 30);
    bus(0, 4'h3, nom);
    bus(0, 4'hf, 0);
    shot(2000, 0, 0, 1000, 0, 0);
    bus(1, 4'h0, 1);
    bus(1, 4'h7, 1);
    act = 1;
    shot(1000, 1000, 307, 150, 151, 999);
    bus(0, 4'h4, 32'h0000_000a);
    chk("irq", 1, irq);
    bus(1, 4'h6, 32'h0000_0007);
    bus(1, 4'h7, 0);
    chk("irq", 0, irq);
    bus(1, 4'h1, 3);
    bus(0, 4'h1, 5);
    bus(1, 4'h2, 32'h0000_00c8);
    bus(0, 4'h2, 32'h0000_0064);
    {ratio, base} = {32'h0000_0005, 32'h0000_0064};
    shot(2000, 0, 0, 200, 0, 0);
    @(posedge core_clk);
    blk <= 1;
    @(posedge core_clk);
    #1 chk("block", 3'h4, {ev, evon, any});
    bus(0, 4'h5, 32'h0000_0006);
    bus(0, 4'h8, 32'h0000_0002);
    act = 0;
    shot(2000, 0, 0, 200, 0, 0);
    blk <= 0;
    act = 1;
    repeat (48) begin
      if ($urandom_range(0, 7) == 0) begin
        {ratio, base, nom} = {$urandom_range(5, 50), $urandom_range(20, 100), $urandom_range(0, 1023)};
        bus(1, 4'h1, ratio);
        bus(1, 4'h2, base);
        bus(1, 4'h3, nom);
      end
      repeat ($urandom_range(0, 2)) @(posedge core_clk);
      shot($urandom_range(0, 2047), $urandom_range(0, 2047), $urandom_range(0, 2047),
        $urandom_range(0, 1023), $urandom_range(0, 1023), $urandom_range(0, 1023));
    end
    tally_and_finish;
  end
endmodule
